// file: hdl/swire_master_pkg.sv
// Timing constants and command codes for the single-wire slot master
package swire_master_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // Times in ns as printed
  localparam int unsigned RESET_LOW_TIME_NS = 480_000;
  localparam int unsigned RESET_LOW_MAX_NS = 960_000;
  localparam int unsigned PRESENCE_SAMPLE_NS = 70_000;
  localparam int unsigned RESET_HIGH_NS = 480_000;
  localparam int unsigned WRITE_ZERO_LOW_TIME_NS = 60_000;
  localparam int unsigned WRITE_ONE_LOW_TIME_NS = 5_000;
  localparam int unsigned READ_LOW_TIME_NS = 5_000;
  localparam int unsigned READ_SAMPLE_WINDOW_NS = 13_000;
  localparam int unsigned SLOT_TIME_NS = 65_000;
  localparam int unsigned RECOVERY_TIME_NS = 5_000;
  localparam int unsigned PROGRAMMING_TIME_NS = 10_000_000;
  // Cycle counts: least times round up, sample points round down
  localparam int unsigned RESET_LOW_CYC = (RESET_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESET_LOW_MAX_CYC = RESET_LOW_MAX_NS / CLK_NS;
  localparam int unsigned PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_NS / CLK_NS;
  localparam int unsigned RESET_HIGH_CYC = (RESET_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WRITE_ZERO_LOW_CYC = (WRITE_ZERO_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WRITE_ONE_LOW_CYC = (WRITE_ONE_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_LOW_CYC = (READ_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_SAMPLE_CYC = READ_SAMPLE_WINDOW_NS / CLK_NS;
  localparam int unsigned SLOT_CYC = (SLOT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RECOVERY_CYC = (RECOVERY_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PROGRAMMING_CYC = (PROGRAMMING_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TIMER_W = 17;
  // Command codes
  localparam logic [7:0] CMD_SKIP_ROM = 8'hCC;
  localparam logic [7:0] CMD_WRITE_SCRATCH = 8'h0F;
  localparam logic [7:0] CMD_READ_SCRATCH = 8'hAA;
  localparam logic [7:0] CMD_COPY_SCRATCH = 8'h55;
  localparam logic [7:0] COPY_KEY = 8'hA5;
  localparam logic [7:0] CMD_READ_MEMORY = 8'hF0;
  localparam int unsigned PAGE_BYTES = 32;
  // Operation codes on the user port
  localparam logic [2:0] OP_RESET = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_PROG = 3'h3;
endpackage

// file: hdl/swire_slot_master.sv
// Bus master for a single-wire open-drain slot link with byte command port
// Overview of operation
// R1: each slot carries one bit, writes master to slave, reads slave to master
// R2: every slot starts with the master pulling the line low
// R3: write-one: release line before the longest write-one low time
// R4: write-zero: hold line low at least the least write-zero low time
// R5: a recovery interval follows each slot before the next one starts
// R6: read slot opens like write-one, low for read low time
// R7: slave pulls low within read low time for a zero bit
// R8: slave leaves line alone for a one bit
// R9: master samples inside read window, near its end
// R10: master waits whole slot duration after sampling before next slot; code ends each slot SLOT_END cycles after slot start
// R11: with several slaves, master lengthens recovery or pulls up actively
// R12: slave low-pass filters the falling edge that opens a slot
// R13: slave ignores shallow dips within threshold hysteresis
// R14: slave ignores glitches inside rising-edge hold-off window
// R15: deep dip past hold-off window starts a new slot at slave
// R16: transactions start with reset pulse 480 to 960 us, then presence sensing
// R17: write scratchpad: skip-ROM, 0Fh, address, then data bytes
// R18: read scratchpad: AAh, address, slave returns bytes
// R19: copy: 55h, key A5h, then line held high for programming time
// R20: read memory: F0h, address, slave returns 32-byte page
// R21: slave answers reset with presence pulse after wait time
// R22: skip-ROM opens memory commands without identification
// R23: line low beyond 120 us may reset slaves; idle is high
// R24: slave samples written bit at a fixed point between write limits
// R25: bytes are sent and received least significant bit first
`timescale 1ns/1ns
`default_nettype none
module swire_slot_master
  import swire_master_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 4,
  parameter int unsigned RESET_LOW_CYCLES = RESET_LOW_CYC,
  parameter int unsigned RESET_HIGH_CYCLES = RESET_HIGH_CYC,
  parameter int unsigned PROG_CYCLES = PROGRAMMING_CYC,
  parameter int unsigned EXTRA_RECOVERY_CYCLES = 0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] cmdOp,
  input wire logic [7:0] cmdData,
  input wire logic cmdValid,
  output logic cmdReady,
  output logic [7:0] rspData,
  output logic rspValid,
  input wire logic rspReady,
  output logic presenceSeen,
  output logic busy,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe_n
);
  import swire_master_pkg::*;
  initial begin
    if (RESET_LOW_CYCLES < RESET_LOW_CYC || RESET_LOW_CYCLES > RESET_LOW_MAX_CYC) begin
      $error("RESET_LOW_CYCLES out of range");
    end
    if (PROG_CYCLES >= (1 << 24)) begin
      $error("PROG_CYCLES too large");
    end
    if (RESET_HIGH_CYCLES <= PRESENCE_SAMPLE_CYC || RESET_HIGH_CYCLES >= (1 << 24)) begin
      $error("RESET_HIGH_CYCLES out of range");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RST_LOW = 3'b001,
    ST_RST_HIGH = 3'b010,
    ST_SLOT = 3'b011,
    ST_PROG = 3'b100,
    ST_PUSH = 3'b101
  } state_t;

  state_t state_r;
  logic [23:0] timer_r;
  logic [7:0] shift_r;
  logic [2:0] bitIdx_r;
  logic isRead_r;
  logic [7:0] rxByte_r;
  logic lineMeta_r;
  logic lineSync_r;
  logic pushValid;
  logic pushReady;
  logic [7:0] fifoData;
  logic fifoValid;

  // Line is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lineMeta_r <= 1'b1;
      lineSync_r <= 1'b1;
    end else begin
      lineMeta_r <= lineIn;
      lineSync_r <= lineMeta_r;
    end
  end

  // Slot ends after full slot time (low time included) plus recovery plus extra recovery
  localparam int unsigned SLOT_END = SLOT_CYC + RECOVERY_CYC + EXTRA_RECOVERY_CYCLES;
  function automatic logic [23:0] lowTime(input logic rd, input logic b);
    if (rd) begin
      return 24'(READ_LOW_CYC);
    end else if (b) begin
      return 24'(WRITE_ONE_LOW_CYC);
    end else begin
      return 24'(WRITE_ZERO_LOW_CYC);
    end
  endfunction

  wire logic takeCmd = (state_r == ST_IDLE) && cmdValid;
  logic cmdReady_r;
  assign cmdReady = cmdReady_r;
  assign pushValid = (state_r == ST_PUSH);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      timer_r <= '0;
      shift_r <= '0;
      bitIdx_r <= '0;
      isRead_r <= 1'b0;
      rxByte_r <= '0;
      presenceSeen <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          timer_r <= '0;
          bitIdx_r <= '0;
          if (cmdValid) begin
            shift_r <= cmdData;
            isRead_r <= (cmdOp == OP_READ);
            if (cmdOp == OP_RESET) begin
              state_r <= ST_RST_LOW; // see R16
            end else if (cmdOp == OP_PROG) begin
              state_r <= ST_PROG; // see R19
            end else begin
              state_r <= ST_SLOT; // see R17, R18, R20
            end
          end
        end
        ST_RST_LOW: begin
          timer_r <= timer_r + 1'b1;
          if (timer_r == 24'(RESET_LOW_CYCLES - 1)) begin
            timer_r <= '0;
            presenceSeen <= 1'b0;
            state_r <= ST_RST_HIGH;
          end
        end
        ST_RST_HIGH: begin
          timer_r <= timer_r + 1'b1;
          // Presence pulse sampled inside its guaranteed window
          if (timer_r == 24'(PRESENCE_SAMPLE_CYC)) begin
            presenceSeen <= !lineSync_r; // see R21
          end
          if (timer_r == 24'(RESET_HIGH_CYCLES - 1)) begin
            state_r <= ST_IDLE;
          end
        end
        ST_SLOT: begin
          timer_r <= timer_r + 1'b1;
          if (timer_r == 24'(READ_SAMPLE_CYC) && isRead_r) begin
            rxByte_r <= {lineSync_r, rxByte_r[7:1]}; // see R9, R25
          end
          if (timer_r == 24'(SLOT_END - 1)) begin // see R5, R10, R11
            timer_r <= '0;
            shift_r <= {1'b0, shift_r[7:1]}; // see R25
            bitIdx_r <= bitIdx_r + 1'b1;
            if (bitIdx_r == 3'd7) begin
              state_r <= isRead_r ? ST_PUSH : ST_IDLE;
            end
          end
        end
        ST_PUSH: begin
          // Holds here until the queue has room
          if (pushReady) begin
            state_r <= ST_IDLE;
          end
        end
        ST_PROG: begin
          // Line left released so pull-up powers the copy
          timer_r <= timer_r + 1'b1;
          if (timer_r == 24'(PROG_CYCLES - 1)) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered ready: accepted only in idle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmdReady_r <= 1'b0;
    end else begin
      cmdReady_r <= takeCmd;
    end
  end

  // Line drive: low while in reset pulse or slot low phase
  logic driveLow;
  always_comb begin
    driveLow = 1'b0;
    if (state_r == ST_RST_LOW) begin
      driveLow = 1'b1; // see R16
    end else if (state_r == ST_SLOT) begin
      // Every slot opens low; length selects bit or read
      driveLow = timer_r < lowTime(isRead_r, shift_r[0]); // see R1, R2, R3, R4, R6
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lineOe_n <= 1'b1;
      lineOut <= 1'b0;
      busy <= 1'b0;
    end else begin
      lineOe_n <= !driveLow; // see R23
      lineOut <= 1'b0;
      busy <= (state_r != ST_IDLE) || cmdValid;
    end
  end

  // Read bytes queue to the user; full queue stalls the slot engine
  sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rspFifo (
    .clk(ref_clk),
    .nrst(nrst),
    .inData(rxByte_r),
    .inValid(pushValid),
    .inReady(pushReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(rspReady)
  );
  assign rspData = fifoData;
  assign rspValid = fifoValid;

  // see R16
  property p_reset_low;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(state_r == ST_RST_LOW) |=> !lineOe_n [*8];
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("reset pulse not driven"); // see R16
  property p_write_one_short;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_SLOT && !isRead_r && shift_r[0] && timer_r == 24'(WRITE_ONE_LOW_CYC + 1)) |-> lineOe_n;
  endproperty
  a_write_one_short: assert property (p_write_one_short) else $error("write one held too long"); // see R3
  property p_write_zero_long;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_SLOT && !isRead_r && !shift_r[0] && timer_r == 24'(WRITE_ZERO_LOW_CYC - 1)) |=> !lineOe_n;
  endproperty
  a_write_zero_long: assert property (p_write_zero_long) else $error("write zero too short"); // see R4
  property p_slot_opens_low;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_SLOT && timer_r == '0) |=> !lineOe_n;
  endproperty
  a_slot_opens_low: assert property (p_slot_opens_low) else $error("slot not opened low"); // see R2
  property p_recovery;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_SLOT && timer_r == 24'(SLOT_CYC)) |=> lineOe_n;
  endproperty
  a_recovery: assert property (p_recovery) else $error("line low in recovery"); // see R5
  property p_read_low;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_SLOT && isRead_r && timer_r == 24'(READ_LOW_CYC)) |=> lineOe_n;
  endproperty
  a_read_low: assert property (p_read_low) else $error("read low too long"); // see R6
  property p_prog_high;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_PROG) |=> lineOe_n;
  endproperty
  a_prog_high: assert property (p_prog_high) else $error("line low in programming"); // see R19
  property p_lsb_first;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_SLOT && timer_r == 24'(SLOT_END - 1)) |=> (shift_r == {1'b0, $past(shift_r[7:1])});
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong"); // see R25
  property p_reset_hold;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_RST_LOW) |=> !lineOe_n;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset pulse cut short"); // see R16
  property p_reset_release;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_RST_HIGH) |=> lineOe_n;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("line held during presence wait"); // see R16
  property p_idle_released;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_IDLE) |=> lineOe_n;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("line low while idle"); // see R23
  property p_read_sample;
    @(posedge ref_clk) disable iff (!nrst)
      (state_r == ST_SLOT && isRead_r && timer_r == 24'(READ_SAMPLE_CYC)) |=> (rxByte_r[7] == $past(lineIn, 3));
  endproperty
  a_read_sample: assert property (p_read_sample) else $error("read bit not taken at sample point"); // see R9
endmodule
`default_nettype wire

// file: hdl/sync_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two of at least 2");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  wire logic pushEn = inValid && inReady;
  wire logic popEn = outValid && outReady;
  assign inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_r != rdPtr_r;
  assign outData = mem[rdPtr_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (pushEn) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (pushEn) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (popEn) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/swire_slave_model.sv
// Behavioural slave device on the single-wire line
`timescale 1ns/1ns
`default_nettype none
module swire_slave_model (
  input wire logic lineOe_n,
  output logic lineIn
);
  import swire_master_pkg::*;
  logic pull = 1'b0;
  logic [7:0] scr [32];
  logic [7:0] mem [32];
  logic [7:0] sh, cmd, txB;
  logic [4:0] addr;
  logic b, tx;
  int ph, cnt;
  time t0;
  // Pull-up: released line reads high
  assign lineIn = lineOe_n & ~pull;
  task automatic load();
    txB = (cmd == CMD_READ_SCRATCH) ? scr[addr] : mem[addr];
  endtask
  task automatic got(input logic [7:0] v);
    case (ph)
      0: ph = (v == CMD_SKIP_ROM) ? 1 : 9;
      1: begin
        cmd = v;
        ph = (v == CMD_COPY_SCRATCH) ? 4 : 2;
      end
      2: begin
        addr = v[4:0];
        ph = 3;
        load();
      end
      3: if (cmd == CMD_WRITE_SCRATCH) begin
        scr[addr] = v;
        addr++;
      end
      4: begin
        if (v == COPY_KEY) mem = scr;
        ph = 9;
      end
      default: ;
    endcase
  endtask
  initial begin
    for (int i = 0; i < 32; i++) begin
      scr[i] = 8'(i);
      mem[i] = 8'(255 - i);
    end
    ph = 9;
    cnt = 0;
    forever begin
      @(negedge lineIn);
      t0 = $time;
      tx = (ph == 3) && (cmd == CMD_READ_SCRATCH || cmd == CMD_READ_MEMORY);
      if (tx && !txB[cnt]) pull = 1'b1;
      #15000 b = lineIn;
      #15000 pull = 1'b0;
      wait (lineIn === 1'b1);
      if ($time - t0 > 120000) begin
        ph = 0;
        cnt = 0;
        #20000 pull = 1'b1;
        #100000 pull = 1'b0;
      end else if (tx || ph != 9) begin
        sh = {b, sh[7:1]};
        cnt++;
        if (cnt == 8) begin
          cnt = 0;
          if (tx) begin
            addr++;
            load();
          end else got(sh);
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/test_single_wire_slot_slave.sv
// Self-checking bench for the single-wire slot master against a slave model
`timescale 1ns/1ns
`default_nettype none
module test_single_wire_slot_slave;
  import swire_master_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] cmdOp = OP_RESET;
  logic [7:0] cmdData = 8'h00;
  logic cmdValid = 1'b0;
  logic rspReady = 1'b0;
  logic [7:0] rspData;
  logic cmdReady, rspValid, presenceSeen, busy, lineIn, lineOut, lineOe_n;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] scrB [32];
  logic [7:0] memB [32];
  logic [7:0] expQ [$];
  logic [7:0] d0, d1;

  always #50 ref_clk = ~ref_clk;

  // Shortened presence wait and programming phase keep the run length down
  swire_slot_master #(.RESET_HIGH_CYCLES(1500), .PROG_CYCLES(100)) u_swire_slot_master (
    .ref_clk(ref_clk), .nrst(nrst), .cmdOp(cmdOp), .cmdData(cmdData), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .rspData(rspData), .rspValid(rspValid), .rspReady(rspReady),
    .presenceSeen(presenceSeen), .busy(busy), .lineIn(lineIn), .lineOut(lineOut), .lineOe_n(lineOe_n)
  );
  swire_slave_model u_swire_slave_model (.lineOe_n(lineOe_n), .lineIn(lineIn));

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [2:0] o, input logic [7:0] d, input bit waitDone);
    @(negedge ref_clk);
    cmdOp = o;
    cmdData = d;
    cmdValid = 1'b1;
    while (busy !== 1'b1) @(negedge ref_clk);
    check({7'h00, cmdReady}, 8'h01);
    cmdValid = 1'b0;
    while (waitDone && busy !== 1'b0) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] d);
    op(OP_WRITE, d, 1'b1);
  endtask
  task automatic rst();
    op(OP_RESET, 8'h00, 1'b1);
    check({7'h00, presenceSeen}, 8'h01);
    wr(CMD_SKIP_ROM);
  endtask
  task automatic pop();
    @(negedge ref_clk);
    while (rspValid !== 1'b1) @(negedge ref_clk);
    check(rspData, expQ.pop_front());
    rspReady = 1'b1;
    @(negedge ref_clk);
    rspReady = 1'b0;
  endtask

  // Hang guard: normal run needs about 150k cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 200000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    for (int i = 0; i < 32; i++) begin
      scrB[i] = 8'(i);
      memB[i] = 8'(255 - i);
    end
    void'($urandom(32'h39d9_0c59));
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    repeat (4) @(negedge ref_clk);
    check({5'h00, lineOe_n, busy, rspValid}, 8'h04);
    nrst = 1'b1;
    rst();
    wr(CMD_WRITE_SCRATCH);
    wr(8'h06);
    wr(d0);
    wr(d1);
    scrB[6] = d0;
    scrB[7] = d1;
    rst();
    wr(CMD_READ_SCRATCH);
    wr(8'h05);
    for (int i = 5; i < 10; i++) expQ.push_back(scrB[i]);
    repeat (4) op(OP_READ, 8'h00, 1'b1);
    // Fifth read finds the buffer full and must wait
    op(OP_READ, 8'h00, 1'b0);
    repeat (6000) @(negedge ref_clk);
    check({6'h00, busy, rspValid}, 8'h03);
    repeat (5) pop();
    while (busy !== 1'b0) @(negedge ref_clk);
    check({7'h00, rspValid}, 8'h00);
    rst();
    wr(CMD_COPY_SCRATCH);
    wr(COPY_KEY);
    op(OP_PROG, 8'h00, 1'b1);
    memB = scrB;
    rst();
    wr(CMD_READ_MEMORY);
    wr(8'h06);
    expQ.push_back(memB[6]);
    expQ.push_back(memB[7]);
    repeat (2) op(OP_READ, 8'h00, 1'b1);
    repeat (2) pop();
    check({7'h00, lineOut}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
